// ==== dv/cks_osc_model.sv ====
// Behavioural oscillators and ready levels on the far side of the switch
`timescale 1ns/1ps
module cks_osc_model #(
    parameter int PRI_DLY = 12,
    parameter int SEC_DLY = 30
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Enables from the switch
    input  wire logic pri_osc_en,
    input  wire logic sec_osc_en,
    input  wire logic fast_osc_en,
    input  wire logic slow_osc_en,
    // Levels and status back to the switch
    output logic      pri_osc_clk,
    output logic      sec_osc_clk,
    output logic      fast_osc_clk,
    output logic      slow_osc_clk,
    output logic      pri_ready,
    output logic      sec_running
);
    logic [4:0] div_q;
    int         pri_cnt_q;
    int         sec_cnt_q;

    // Divider and start-up counts; a disabled source must start over
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_q     <= 5'h00;
            pri_cnt_q <= 0;
            sec_cnt_q <= 0;
        end else begin
            div_q     <= div_q + 5'h01;
            pri_cnt_q <= pri_osc_en ? ((pri_cnt_q < PRI_DLY) ? pri_cnt_q + 1 : pri_cnt_q) : 0;
            sec_cnt_q <= sec_osc_en ? ((sec_cnt_q < SEC_DLY) ? sec_cnt_q + 1 : sec_cnt_q) : 0;
        end
    end

    // Stopped sources rest low; all run slower than half the system clock
    assign pri_osc_clk  = pri_osc_en & div_q[1];
    assign fast_osc_clk = fast_osc_en & div_q[2];
    assign sec_osc_clk  = sec_osc_en & div_q[3];
    assign slow_osc_clk = slow_osc_en & div_q[4];
    assign pri_ready    = pri_osc_en && (pri_cnt_q >= PRI_DLY);
    assign sec_running  = sec_osc_en && (sec_cnt_q >= SEC_DLY);
endmodule // cks_osc_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the power-mode clock switch
`timescale 1ns/1ps
module tb_top import cks_pkg::*;;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic       clock = 1'b0;
    logic       resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0, rd = 1'b0, sleep_exec = 1'b0, wake_event = 1'b0;
    logic [7:0] rdata, v;
    logic       pri_osc_clk, sec_osc_clk, fast_osc_clk, slow_osc_clk, pri_ready, sec_running;
    logic       dev_clk, cpu_clk_en, periph_clk_en;
    logic       pri_osc_en, sec_osc_en, fast_osc_en, slow_osc_en;
    int         fail_count = 0;
    int         checks_done = 0;

    always #50 clock = ~clock;

    cks_power_clock dut (.clock, .resetn, .addr, .wdata, .wr, .rd, .rdata, .sleep_exec,
        .wake_event, .pri_osc_clk, .sec_osc_clk, .fast_osc_clk, .slow_osc_clk, .pri_ready,
        .sec_running, .dev_clk, .cpu_clk_en, .periph_clk_en, .pri_osc_en, .sec_osc_en,
        .fast_osc_en, .slow_osc_en);
    cks_osc_model #(.PRI_DLY(12), .SEC_DLY(30)) osc (.clock, .resetn, .pri_osc_en,
        .sec_osc_en, .fast_osc_en, .slow_osc_en, .pri_osc_clk, .sec_osc_clk, .fast_osc_clk,
        .slow_osc_clk, .pri_ready, .sec_running);

    // ---------------------------------------------------------------
    // Access tasks and comparison
    // ---------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask

    // Bounded poll: a switch ends when the synchronised flags settle
    task automatic poll(input logic [1:0] a, input logic [7:0] e);
        for (int i = 0; i < 300; i++) begin
            rd_reg(a, v);
            if (v === e) break;
        end
        check(v, e);
        if (v !== e) test_done;
    endtask

    // One-cycle core event, then let the registered enables land
    task automatic event_pulse(input logic to_sleep);
        @(posedge clock);
        if (to_sleep) sleep_exec <= 1'b1;
        else wake_event <= 1'b1;
        @(posedge clock);
        sleep_exec <= 1'b0;
        wake_event <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd_reg(OFS_OSC_CTRL, v);
        check(v, 8'h08);
        rd_reg(OFS_TMR_CTRL, v);
        check(v, RST_TMR_CTRL);
        rd_reg(2'h3, v);
        check(v, 8'h00);
        // Timer source picked while its oscillator is off: no switch
        wr_reg(OFS_OSC_CTRL, 8'h01);
        repeat (60) @(posedge clock);
        rd_reg(OFS_OSC_CTRL, v);
        check(v, 8'h09);
        wr_reg(OFS_TMR_CTRL, 8'h08);
        poll(OFS_TMR_CTRL, 8'h48);
        poll(OFS_OSC_CTRL, 8'h01);
        check({7'h00, pri_osc_en}, 8'h00);
        wr_reg(OFS_OSC_CTRL, 8'h00);
        poll(OFS_OSC_CTRL, 8'h08);
        rd_reg(OFS_TMR_CTRL, v);
        check(v, 8'h08);
        check({7'h00, sec_osc_en}, 8'h01);
        // Internal run with the lower select bit cleared as advised
        wr_reg(OFS_OSC_CTRL, 8'h02);
        poll(OFS_OSC_CTRL, 8'h02);
        check({6'h00, fast_osc_en, pri_osc_en}, 8'h00);
        wr_reg(OFS_OSC_CTRL, 8'h72);
        poll(OFS_OSC_CTRL, 8'h76);
        wr_reg(OFS_OSC_CTRL, 8'h70);
        poll(OFS_OSC_CTRL, 8'h78);
        // Sleep with watchdog selected and timer oscillator enabled
        wr_reg(OFS_CFG, 8'h04);
        event_pulse(1'b1);
        check({4'h0, pri_osc_en, dev_clk, cpu_clk_en, periph_clk_en}, 8'h00);
        check({6'h00, sec_osc_en, slow_osc_en}, 8'h03);
        rd_reg(OFS_OSC_CTRL, v);
        check(v, 8'h70);
        event_pulse(1'b0);
        check({7'h00, cpu_clk_en}, 8'h00);
        poll(OFS_OSC_CTRL, 8'h78);
        check({7'h00, cpu_clk_en}, 8'h01);
        // Idle bit sampled at each sleep instruction
        wr_reg(OFS_OSC_CTRL, 8'hf0);
        event_pulse(1'b1);
        check({6'h00, cpu_clk_en, periph_clk_en}, 8'h01);
        event_pulse(1'b0);
        wr_reg(OFS_OSC_CTRL, 8'h70);
        event_pulse(1'b1);
        check({6'h00, cpu_clk_en, periph_clk_en}, 8'h00);
        event_pulse(1'b0);
        poll(OFS_OSC_CTRL, 8'h78);
        // Two-speed wake runs the core at once from the internal block
        wr_reg(OFS_CFG, 8'h05);
        event_pulse(1'b1);
        event_pulse(1'b0);
        check({7'h00, cpu_clk_en}, 8'h01);
        poll(OFS_OSC_CTRL, 8'h78);
        test_done;
    end
endmodule // tb_top

// ==== src/cks_edge_count.sv ====
// Counter of falling edges on a sampled clock level
`timescale 1ns/1ps
module cks_edge_count import cks_pkg::*; (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Control
    input  wire logic       level,
    input  wire logic       clear,
    input  wire logic [2:0] target,
    output logic            done
);

    logic       prev_q;
    logic [2:0] cnt_q;
    wire        fall = prev_q & ~level;

    // Count falls until the target; clear holds it at zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
            cnt_q  <= 3'h0;
            done   <= 1'b0;
        end else begin
            prev_q <= level;
            if (clear) begin
                cnt_q <= 3'h0;
                done  <= 1'b0;
            end else if (fall && cnt_q != target) begin
                cnt_q <= cnt_q + 3'h1;
                done  <= (cnt_q + 3'h1) == target;
            end
        end
    end

endmodule // cks_edge_count

// ==== src/cks_pkg.sv ====
// Package of constants for the power-mode clock switch
package cks_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 100;   // 10 MHz system clock
    localparam int unsigned STAB_TIME_NS   = 1000;  // Fast internal stabilise time
    localparam int unsigned STAB_CYCLES    =
        (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  OLD_EDGES      = 3'h2;  // Outgoing source cycles
    localparam logic [2:0]  NEW_EDGES      = 3'h3;  // Incoming source cycles

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [1:0] OFS_OSC_CTRL   = 2'h0;  // oscillator_control_register
    localparam logic [1:0] OFS_TMR_CTRL   = 2'h1;  // timer_control_register
    localparam logic [1:0] OFS_CFG        = 2'h2;  // Option straps

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int unsigned POS_IDLE      = 7;     // idle_enable_bit
    localparam int unsigned POS_FREQ_HI   = 6;     // internal_frequency_select
    localparam int unsigned POS_FREQ_LO   = 4;
    localparam int unsigned POS_PRI_FLAG  = 3;     // primary_running_flag
    localparam int unsigned POS_INT_FLAG  = 2;     // internal_stable_flag
    localparam int unsigned POS_SEL_HI    = 1;     // clock_source_select
    localparam int unsigned POS_SEL_LO    = 0;
    localparam int unsigned POS_SEC_FLAG  = 6;     // secondary_running_flag
    localparam int unsigned POS_TOSC_EN   = 3;     // timer_oscillator_enable
    localparam int unsigned POS_TWO_SPEED = 0;
    localparam int unsigned POS_FAIL_SAFE = 1;
    localparam int unsigned POS_WATCHDOG  = 2;
    localparam int unsigned POS_PRI_INT   = 3;     // Primary is the internal block
    localparam int unsigned POS_INT_SRC   = 4;     // internal_source_select

    // ---------------------------------------------------------------
    // Reset values and encodings
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_OSC_CTRL   = 8'h00;
    localparam logic [7:0] RST_TMR_CTRL   = 8'h00;
    localparam logic [7:0] RST_CFG        = 8'h00;
    localparam logic [1:0] SRC_PRI        = 2'h0;
    localparam logic [1:0] SRC_SEC        = 2'h1;
    localparam logic [1:0] SRC_INT        = 2'h2;
    localparam logic [2:0] FREQ_FULL      = 3'h7;  // Fast source undivided

    typedef enum logic [6:0] {
        ST_RUN   = 7'b0000001,
        ST_WAIT  = 7'b0000010,
        ST_OLD   = 7'b0000100,
        ST_NEW   = 7'b0001000,
        ST_IDLE  = 7'b0010000,
        ST_SLEEP = 7'b0100000,
        ST_WAKE  = 7'b1000000
    } cks_state_t;

endpackage

// ==== src/cks_power_clock.sv ====
// Clock-source switch and power-mode controller
//
// Behaviour
// R1 - Switch takes 2 old, 3-4 new cycles
// R2 - Three status flags at fixed bit positions
// R3 - Each flag shows its source driving clock
// R4 - At most one flag set normally
// R5 - Internal primary may show two flags
// R6 - Sleep instruction samples idle bit each time
// R7 - Reset starts primary run, primary flag set
// R8 - Select 01 switches to timer oscillator
// R9 - Timer oscillator disabled blocks secondary run
// R10 - Return to primary waits primary ready
// R11 - Upper select bit picks internal run
// R12 - Frequency select changes speed immediately
// R13 - All-zero select keeps fast source off
// R14 - Internal flag set after stabilisation
// R15 - Already stable keeps internal flag set
// R16 - Internal to primary waits primary ready
// R17 - Idle clear sleep stops clocks, flags
// R18 - Sleep keeps watchdog and timer oscillators
// R19 - Wake waits source or uses internal
// R20 - Idle bit 7, select bits 1:0
// R21 - Glitch-free changeover at low phases
// R22 - Flags resampled on device clock
`timescale 1ns/1ps
module cks_power_clock import cks_pkg::*; (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // Register port
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Core events
    input  wire logic       sleep_exec,
    input  wire logic       wake_event,
    // Oscillator levels and status
    input  wire logic       pri_osc_clk,
    input  wire logic       sec_osc_clk,
    input  wire logic       fast_osc_clk,
    input  wire logic       slow_osc_clk,
    input  wire logic       pri_ready,
    input  wire logic       sec_running,
    // Clock outputs and oscillator enables
    output logic            dev_clk,
    output logic            cpu_clk_en,
    output logic            periph_clk_en,
    output logic            pri_osc_en,
    output logic            sec_osc_en,
    output logic            fast_osc_en,
    output logic            slow_osc_en
);

    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    cks_state_t  st_q;
    logic        idle_q;
    logic [2:0]  freq_q;
    logic [1:0]  sel_q;
    logic        tosc_en_q;
    logic [7:0]  cfg_q;
    logic [1:0]  cur_q;
    logic [1:0]  mux_q;
    logic        gate_q;
    logic [7:0]  stab_q;
    logic [6:0]  post_q;
    logic        fast_prev_q;
    logic        dev_prev_q;
    logic [2:0]  flags_q;   // {sec, int, pri} as seen by software
    logic [3:0]  lvl_s;     // {slow, fast, sec, pri} synchronised

    // ---------------------------------------------------------------
    // Oscillator level synchronisers
    // ---------------------------------------------------------------
    cks_sync2 #(.WIDTH(4)) u_sync (
        .clock  (clock),
        .resetn (resetn),
        .din    ({slow_osc_clk, fast_osc_clk, sec_osc_clk, pri_osc_clk}),
        .dout   (lvl_s)
    );

    // ---------------------------------------------------------------
    // Decode of register fields and options
    // ---------------------------------------------------------------
    wire two_speed = cfg_q[POS_TWO_SPEED];
    wire fail_safe = cfg_q[POS_FAIL_SAFE];
    wire watchdog  = cfg_q[POS_WATCHDOG];
    wire pri_int   = cfg_q[POS_PRI_INT];
    wire int_src   = cfg_q[POS_INT_SRC];
    wire is_sleep  = (st_q == ST_SLEEP) || (st_q == ST_WAKE);
    // Fast source enabled by a non-zero frequency or the source bit
    wire fast_on   = ((freq_q != 3'h0) || int_src) && !is_sleep;     // [R13] [R14]
    wire fast_stab = fast_on && (stab_q == 8'(STAB_CYCLES));

    // Requested source: upper bit wins, 01 needs the timer oscillator
    wire [1:0] want = sel_q[POS_SEL_HI] ? SRC_INT :                 // [R11] [R20]
                      (sel_q == 2'h1) ? (tosc_en_q ? SRC_SEC : cur_q) : // [R8] [R9]
                      SRC_PRI;

    // Internal multiplexer: postscaled fast source, or the slow one
    wire [2:0] post_idx = 3'h6 - freq_q;
    wire int_lvl = !fast_on ? lvl_s[3] :                              // [R13]
                   (freq_q == FREQ_FULL) ? lvl_s[2] : post_q[post_idx]; // [R12]

    // Level and readiness per source
    wire [2:0] src_lvl = {int_lvl, lvl_s[1], lvl_s[0]};
    wire [2:0] src_rdy = {1'b1, sec_running, pri_ready};
    wire cur_lvl  = src_lvl[cur_q];
    wire want_lvl = src_lvl[want];
    wire mux_lvl  = src_lvl[mux_q];
    wire want_rdy = src_rdy[want];

    // ---------------------------------------------------------------
    // Changeover cycle counters
    // ---------------------------------------------------------------
    logic old_done;
    logic new_done;

    cks_edge_count u_old (
        .clock  (clock),
        .resetn (resetn),
        .level  (cur_lvl),
        .clear  (st_q != ST_OLD),
        .target (OLD_EDGES),
        .done   (old_done)
    );

    cks_edge_count u_new (
        .clock  (clock),
        .resetn (resetn),
        .level  (want_lvl),
        .clear  (st_q != ST_NEW),
        .target (NEW_EDGES),
        .done   (new_done)
    );

    // ---------------------------------------------------------------
    // Gate request and raw status
    // ---------------------------------------------------------------
    // Clocks stop while waiting on a stalled timer oscillator
    wire sec_stall = (want == SRC_SEC) && !sec_running;                // [R9]
    wire gate_want = (st_q == ST_RUN) || (st_q == ST_IDLE) ||
                     ((st_q == ST_WAIT) && !sec_stall);
    wire running   = !is_sleep;
    wire pri_raw   = running && (cur_q == SRC_PRI);                    // [R3] [R7]
    wire sec_raw   = running && (cur_q == SRC_SEC);                    // [R3]
    // Internal flag also follows an internal primary; a move to internal run
    // drops the primary flag because the current source changes
    wire int_raw   = running && fast_stab &&                           // [R5] [R15]
                     ((cur_q == SRC_INT) || ((cur_q == SRC_PRI) && pri_int));
    wire dev_rise  = dev_clk & ~dev_prev_q;
    wire rd_pick   = (addr == OFS_OSC_CTRL) || (addr == OFS_TMR_CTRL) ||
                     (addr == OFS_CFG);

    // Read multiplexer; unmapped offsets read zero
    wire [7:0] osc_rd = {idle_q, freq_q, flags_q[0], flags_q[1], sel_q}; // [R2]
    wire [7:0] tmr_rd = 8'({flags_q[2], 2'h0, tosc_en_q, 3'h0});       // [R2]
    wire [7:0] rd_val = !rd_pick ? 8'h00 :
                        (addr == OFS_OSC_CTRL) ? osc_rd :
                        (addr == OFS_TMR_CTRL) ? tmr_rd : cfg_q;

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    // Writes during a changeover take effect at the next decision point
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            idle_q    <= RST_OSC_CTRL[POS_IDLE];
            freq_q    <= RST_OSC_CTRL[POS_FREQ_HI:POS_FREQ_LO];
            sel_q     <= RST_OSC_CTRL[POS_SEL_HI:POS_SEL_LO];
            tosc_en_q <= RST_TMR_CTRL[POS_TOSC_EN];
            cfg_q     <= RST_CFG;
        end else if (wr) begin
            if (addr == OFS_OSC_CTRL) begin
                idle_q <= wdata[POS_IDLE];                             // [R20]
                freq_q <= wdata[POS_FREQ_HI:POS_FREQ_LO];
                sel_q  <= wdata[POS_SEL_HI:POS_SEL_LO];
            end
            if (addr == OFS_TMR_CTRL) begin
                tosc_en_q <= wdata[POS_TOSC_EN];
            end
            if (addr == OFS_CFG) begin
                cfg_q <= wdata;
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rd_val : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Fast internal source: stabilise timer and postscaler
    // ---------------------------------------------------------------
    // Timer restarts only when the source goes off, so a mode change
    // does not interrupt a flag that is already set
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stab_q      <= 8'h00;
            post_q      <= 7'h00;
            fast_prev_q <= 1'b0;
        end else begin
            fast_prev_q <= lvl_s[2];
            if (!fast_on) begin
                stab_q <= 8'h00;                                       // [R13]
            end else if (stab_q != 8'(STAB_CYCLES)) begin
                stab_q <= stab_q + 8'h01;                              // [R14]
            end
            if (lvl_s[2] && !fast_prev_q) begin
                post_q <= post_q + 7'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Mode and changeover sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q  <= ST_RUN;                                           // [R7]
            cur_q <= SRC_PRI;
            mux_q <= SRC_PRI;
        end else begin
            case (st_q)
                ST_RUN: begin
                    if (sleep_exec) begin
                        st_q <= idle_q ? ST_IDLE : ST_SLEEP;           // [R6] [R17]
                    end else if (want != cur_q) begin
                        st_q <= ST_WAIT;
                    end
                end
                // Keep the old source until the new one is ready
                ST_WAIT: begin
                    if (want == cur_q) begin
                        st_q <= ST_RUN;
                    end else if (want_rdy) begin                       // [R10] [R16]
                        st_q <= ST_OLD;
                    end
                end
                ST_OLD: begin
                    if (old_done && !gate_q) begin                     // [R1] [R21]
                        mux_q <= want;
                        st_q  <= ST_NEW;
                    end
                end
                ST_NEW: begin
                    if (mux_q != want) begin
                        st_q <= ST_WAIT;
                    end else if (new_done) begin                       // [R1]
                        cur_q <= want;
                        st_q  <= ST_RUN;
                    end
                end
                ST_IDLE: begin
                    if (wake_event) begin
                        st_q <= ST_RUN;
                    end
                end
                ST_SLEEP: begin
                    if (wake_event) begin
                        if (two_speed || fail_safe) begin              // [R19]
                            cur_q <= SRC_INT;
                            mux_q <= SRC_INT;
                            st_q  <= ST_RUN;
                        end else begin
                            st_q <= ST_WAKE;
                        end
                    end
                end
                ST_WAKE: begin
                    if (want_rdy) begin                                // [R19]
                        cur_q <= want;
                        mux_q <= want;
                        st_q  <= ST_RUN;
                    end
                end
                default: begin
                    st_q <= ST_RUN;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Device clock, gate and status sampling
    // ---------------------------------------------------------------
    // Gate moves only while the muxed level is low, so no runt pulse
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            gate_q     <= 1'b1;
            dev_clk    <= 1'b0;
            dev_prev_q <= 1'b0;
            flags_q    <= 3'b001;
        end else begin
            if (!mux_lvl) begin
                gate_q <= gate_want;                                   // [R21]
            end
            dev_clk    <= gate_q & mux_lvl;
            dev_prev_q <= dev_clk;
            if (dev_rise || is_sleep) begin
                flags_q <= {sec_raw, int_raw, pri_raw};                // [R22] [R17]
            end
        end
    end

    // ---------------------------------------------------------------
    // Core clock enables and oscillator enables
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            pri_osc_en    <= 1'b1;
            sec_osc_en    <= 1'b0;
            fast_osc_en   <= 1'b0;
            slow_osc_en   <= 1'b1;
        end else begin
            cpu_clk_en    <= !is_sleep && (st_q != ST_IDLE);
            periph_clk_en <= !is_sleep;
            // Primary stops once another source has taken over
            pri_osc_en    <= ((cur_q == SRC_PRI) || (want == SRC_PRI)) &&
                             (st_q != ST_SLEEP);                       // [R8] [R11]
            sec_osc_en    <= tosc_en_q;                                // [R18] [R10]
            fast_osc_en   <= fast_on;
            slow_osc_en   <= !is_sleep || watchdog;                    // [R18]
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence old_phase_s;
        (st_q == ST_OLD) ##1 (st_q == ST_NEW);
    endsequence

    sequence new_phase_s;
        (st_q == ST_NEW) ##1 (st_q == ST_RUN);
    endsequence

    // Checks what software reads; only an internal primary may show two flags
    flags_exclusive_a: assert property ( // [R4]
        $onehot0(flags_q) || ((flags_q == 3'b011) && pri_int))
        else $error("two clock status flags set at once");

    old_cycles_a: assert property ( // [R1]
        old_phase_s |-> $past(old_done))
        else $error("left the outgoing source early");

    new_cycles_a: assert property ( // [R1]
        new_phase_s |-> $past(new_done) && (cur_q == $past(want)))
        else $error("incoming source taken too early");

    mux_safe_a: assert property ( // [R21]
        (mux_q != $past(mux_q)) && $past(st_q == ST_OLD) |-> !gate_q && !dev_clk)
        else $error("source changed with the gate open");

    sleep_pick_a: assert property ( // [R6]
        (st_q == ST_RUN) && sleep_exec |=>
        st_q == ($past(idle_q) ? ST_IDLE : ST_SLEEP))
        else $error("sleep instruction chose the wrong mode");

    sleep_flags_a: assert property ( // [R17]
        (st_q == ST_SLEEP) ##1 (st_q == ST_SLEEP) |-> flags_q == 3'b000)
        else $error("status flags left set in sleep");

    sec_blocked_a: assert property ( // [R9]
        (sel_q == 2'h1) && !tosc_en_q && (cur_q != SRC_SEC) |=> cur_q != SRC_SEC)
        else $error("secondary run entered with timer oscillator off");

    wait_hold_a: assert property ( // [R10]
        (st_q == ST_WAIT) && !want_rdy |=> (cur_q == $past(cur_q)) && (st_q != ST_OLD))
        else $error("changeover began before the source was ready");

    int_off_a: assert property ( // [R13]
        (freq_q == 3'h0) && !int_src |=> !fast_osc_en && (stab_q == 8'h00))
        else $error("fast internal source enabled with all-zero select");

    flag_resample_a: assert property ( // [R22]
        !dev_rise && !is_sleep |=> flags_q == $past(flags_q))
        else $error("status flags changed off the device clock");

endmodule // cks_power_clock

// ==== src/cks_sync2.sv ====
// Two-flop synchroniser for the oscillator level inputs
`timescale 1ns/1ps
module cks_sync2 import cks_pkg::*; #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule // cks_sync2
